// ---- common/drive_cw_map.svh ----
// offsets, bit positions and state codes of the control word block
`ifndef DRIVE_CW_MAP_SVH
`define DRIVE_CW_MAP_SVH

`define CW_OFS_CTRL      8'h00
`define CW_OFS_SP_WAIT   8'h04
`define CW_OFS_DEENERG   8'h08
`define CW_OFS_INCH1     8'h0C
`define CW_OFS_INCH2     8'h10
`define CW_OFS_STATUS    8'h14

`define CW_BIT_ON        0
`define CW_BIT_SP_EN     6
`define CW_BIT_ACK       7
`define CW_BIT_INCH1     8
`define CW_BIT_INCH2     9
`define CW_CTRL_MASK     16'h03C1
`define CW_CTRL_RST      16'h0000

`define ST_BIT_SP_EN     0
`define ST_BIT_ON        1
`define ST_BIT_INCH_RUN  2
`define ST_BIT_INCH_WAIT 3
`define ST_BIT_INCH2     4
`define ST_BIT_DEEN_DONE 5
`define ST_BIT_SPW_DONE  6
`define ST_BIT_ACK_BUSY  7
`define ST_BIT_HOLD      8
`define ST_BIT_FAULT     9
`define ST_CODE_LSB      16

`define DRV_ST_FAULT     8'h07
`define DRV_ST_PON_INH   8'h08
`define DRV_ST_READY_PU  8'h09

`endif

// ---- common/drive_cw_pkg.sv ----
// enumerations of the control word block
`default_nettype none

package drive_cw_pkg;

	typedef enum logic [1:0] {
		ACK_IDLE  = 2'b00,
		ACK_COPY  = 2'b01,
		ACK_CLEAR = 2'b10,
		ACK_CHECK = 2'b11
	} ack_state_t;

	typedef enum logic [1:0] {
		INCH_IDLE = 2'b00,
		INCH_WAIT = 2'b01,
		INCH_RUN  = 2'b10
	} inch_state_t;

	typedef enum logic [1:0] {
		SEL_MAIN  = 2'b00,
		SEL_INCH1 = 2'b01,
		SEL_INCH2 = 2'b10
	} sp_sel_t;

endpackage : drive_cw_pkg

`default_nettype wire

// ---- test/drive_cw_bits_tb.sv ----
// self-checking bench for the control word block
`timescale 1ns/10ps
`default_nettype none

`include "drive_cw_map.svh"

module drive_cw_bits_tb;
	logic        clock = 1'h0;
	logic        sys_rst = 1'h1;
	logic [7:0]  bus_addr = 8'h00;
	logic [31:0] bus_wdata = 32'h0;
	logic        bus_wr = 1'h0;
	logic        bus_rd = 1'h0;
	logic [31:0] bus_rdata;
	logic [3:0]  pins = 4'h0;
	logic        shutdown_done = 1'h0;
	logic [7:0]  m_code = 8'h00;
	logic        m_load = 1'h0;
	logic        m_fault = 1'h0;
	logic [15:0] m_faults = 16'h0;
	logic [7:0]  state_code;
	logic        fault_present, setpoint_enable, on_command, ramp_down_stop;
	logic        diag_wr, fault_clear, power_on_inhibit_req, hold_fault;
	logic [1:0]  setpoint_select;
	logic [15:0] pending_faults, inching_setpoint, diag_data, diag_seen;
	int          n_errors = 0, checks_done = 0, n_diag = 0, n_ramp = 0, cyc = 0;

	always #2 clock = ~clock;

	drive_cw_bits dut (.clock, .sys_rst, .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata,
		.ack_src_pin(pins[2:0]), .panel_ack_pin(pins[3]), .state_code, .fault_present,
		.pending_faults, .shutdown_done, .setpoint_enable, .on_command, .ramp_down_stop,
		.setpoint_select, .inching_setpoint, .diag_wr, .diag_data, .fault_clear,
		.power_on_inhibit_req, .hold_fault);

	drive_far_model far (.clock, .sys_rst, .code_in(m_code), .load(m_load), .fault_in(m_fault),
		.faults_in(m_faults), .fault_clear, .power_on_inhibit_req, .state_code,
		.fault_present, .pending_faults);

	////////////////////////////////////////////////////////////////////////////////
	task automatic give_verdict();
		$display("errors %0d checks %0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : give_verdict

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : tick

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		bus_addr  <= a;
		bus_wdata <= d;
		bus_wr    <= 1'h1;
		@(posedge clock);
		bus_wr <= 1'h0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clock);
		bus_addr <= a;
		bus_rd   <= 1'h1;
		@(posedge clock);
		bus_rd <= 1'h0;
		#1;
		chk(bus_rdata, e);
	endtask : rd

	task automatic set_st(input logic [7:0] c, input logic f, input logic [15:0] p);
		@(posedge clock);
		m_code   <= c;
		m_fault  <= f;
		m_faults <= p;
		m_load   <= 1'h1;
		@(posedge clock);
		m_load <= 1'h0;
	endtask : set_st

	task automatic sd_pulse();
		@(posedge clock);
		shutdown_done <= 1'h1;
		@(posedge clock);
		shutdown_done <= 1'h0;
	endtask : sd_pulse

	////////////////////////////////////////////////////////////////////////////////
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (diag_wr === 1'h1) begin
			n_diag    <= n_diag + 1;
			diag_seen <= diag_data;
		end
		if (ramp_down_stop === 1'h1)
			n_ramp <= n_ramp + 1;
		if (cyc == 5000) begin
			n_errors++;
			give_verdict();
		end
	end

	initial begin
		tick(20);
		@(posedge clock) sys_rst <= 1'h0;
		rd(`CW_OFS_SP_WAIT, 32'h100);
		rd(`CW_OFS_DEENERG, 32'h100);
		rd(8'h18, 32'h0);
		wr(`CW_OFS_SP_WAIT, 32'h6);
		wr(`CW_OFS_DEENERG, 32'hA);
		wr(`CW_OFS_INCH1, 32'h1234);
		wr(`CW_OFS_INCH2, 32'h5678);
		rd(`CW_OFS_INCH2, 32'h5678);
		wr(`CW_OFS_CTRL, 32'h40);
		tick(4);
		chk(setpoint_enable, 1'h1);
		sd_pulse();
		tick(3);
		chk(setpoint_enable, 1'h0);
		tick(12);
		chk(setpoint_enable, 1'h1);
		wr(`CW_OFS_CTRL, 32'h0);
		tick(4);
		chk(setpoint_enable, 1'h0);
		set_st(`DRV_ST_READY_PU, 1'h0, 16'hA5C3);
		wr(`CW_OFS_CTRL, 32'h80);
		tick(10);
		chk(n_diag, 0);
		wr(`CW_OFS_CTRL, 32'h0);
		for (int i = 0; i < 2; i++) begin
			set_st(`DRV_ST_FAULT, i[0], 16'hA5C3);
			wr(`CW_OFS_CTRL, 32'h80);
			tick(10);
			chk(n_diag, i + 1);
			chk(diag_seen, 16'hA5C3);
			chk(pending_faults, 16'h0);
			chk(state_code, i ? `DRV_ST_FAULT : `DRV_ST_PON_INH);
			chk(hold_fault, i[0]);
			rd(`CW_OFS_STATUS, i ? 32'h00070360 : 32'h00080060);
			wr(`CW_OFS_CTRL, 32'h0);
		end
		set_st(`DRV_ST_READY_PU, 1'h0, 16'h0);
		tick(3);
		chk(hold_fault, 1'h0);
		for (int i = 0; i < 4; i++) begin
			set_st(`DRV_ST_FAULT, 1'h0, 16'h1 << i);
			@(posedge clock) pins <= 4'h1 << i;
			tick(4);
			@(posedge clock) pins <= 4'h0;
			tick(8);
			chk(diag_seen, 16'h1 << i);
			chk(state_code, `DRV_ST_PON_INH);
		end
		for (int k = 0; k < 2; k++) begin
			set_st(`DRV_ST_READY_PU, 1'h0, 16'h0);
			sd_pulse();
			wr(`CW_OFS_CTRL, 32'h1 | (32'h100 << k));
			tick(2);
			chk(on_command, 1'h0);
			tick(12);
			chk(on_command, 1'h1);
			chk(setpoint_select, k + 1);
			chk(inching_setpoint, k ? 16'h5678 : 16'h1234);
			wr(`CW_OFS_CTRL, 32'h100 << k);
			tick(3);
			chk(on_command, 1'h1);
			wr(`CW_OFS_CTRL, 32'h1);
			tick(5);
			chk(n_ramp, k + 1);
			chk(setpoint_select, 2'h0);
			chk(on_command, 1'h1);
			wr(`CW_OFS_CTRL, 32'h0);
		end
		give_verdict();
	end
endmodule : drive_cw_bits_tb
`default_nettype wire

// ---- test/drive_cw_checker.sv ----
// port assertions of the control word block
`timescale 1ns/10ps
`default_nettype none

`include "drive_cw_map.svh"

module drive_cw_checker #(
	parameter int NF = 16
) (
	input wire logic          clock,
	input wire logic          sys_rst,
	input wire logic [7:0]    state_code,
	input wire logic          fault_present,
	input wire logic [NF-1:0] pending_faults,
	input wire logic          shutdown_done,
	input wire logic          setpoint_enable,
	input wire logic          on_command,
	input wire logic          ramp_down_stop,
	input wire logic [1:0]    setpoint_select,
	input wire logic          diag_wr,
	input wire logic [NF-1:0] diag_data,
	input wire logic          fault_clear,
	input wire logic          power_on_inhibit_req,
	input wire logic          hold_fault
);
	default clocking dc @(posedge clock); endclocking
	default disable iff (sys_rst);

	a_sp_wait_restart: assert property (
		shutdown_done |-> ##3 (!setpoint_enable)[*2])
		else $error("setpoint enabled during wait");
	a_ack_in_fault: assert property (
		diag_wr |-> $past(state_code, 2) == `DRV_ST_FAULT)
		else $error("acknowledge outside fault state");
	a_copy_then_clear: assert property (
		diag_wr |=> fault_clear)
		else $error("clear does not follow copy");
	a_copy_snapshot: assert property (
		diag_wr |-> diag_data == $past(pending_faults))
		else $error("diagnostics copy wrong");
	a_clear_ends_pon: assert property (
		fault_clear && !fault_present |=> power_on_inhibit_req)
		else $error("no power-on inhibit request");
	a_fault_holds: assert property (
		fault_clear && fault_present |=> hold_fault && !power_on_inhibit_req)
		else $error("persisting fault not held");
	a_inch1_on: assert property (
		$rose(setpoint_select == drive_cw_pkg::SEL_INCH1) |-> on_command)
		else $error("inching 1 without on");
	a_inch2_on: assert property (
		$rose(setpoint_select == drive_cw_pkg::SEL_INCH2) |-> on_command)
		else $error("inching 2 without on");
	a_inch_keeps_on: assert property (
		setpoint_select != 2'h0 |-> on_command && !ramp_down_stop)
		else $error("on dropped while inching");
	a_inch_waits: assert property (
		shutdown_done |=> (!$rose(setpoint_select != 2'h0))[*3])
		else $error("inching started before wait");
	a_stop_drops_on: assert property (
		ramp_down_stop |-> !on_command ##1 !ramp_down_stop)
		else $error("stop pulse wrong");

	cover property (power_on_inhibit_req);
	cover property (hold_fault);
	cover property (ramp_down_stop);
	cover property (setpoint_select == drive_cw_pkg::SEL_INCH2);
endmodule : drive_cw_checker

bind drive_cw_bits drive_cw_checker #(.NF(NF)) u_chk (.clock(clock), .sys_rst(sys_rst),
	.state_code(state_code), .fault_present(fault_present), .pending_faults(pending_faults),
	.shutdown_done(shutdown_done), .setpoint_enable(setpoint_enable), .on_command(on_command),
	.ramp_down_stop(ramp_down_stop), .setpoint_select(setpoint_select), .diag_wr(diag_wr),
	.diag_data(diag_data), .fault_clear(fault_clear),
	.power_on_inhibit_req(power_on_inhibit_req), .hold_fault(hold_fault));
`default_nettype wire

// ---- test/drive_far_model.sv ----
// far side: drive sequencer holding state code and pending faults
`timescale 1ns/10ps
`default_nettype none

`include "drive_cw_map.svh"

module drive_far_model (
	input  wire logic        clock,
	input  wire logic        sys_rst,
	input  wire logic [7:0]  code_in,
	input  wire logic        load,
	input  wire logic        fault_in,
	input  wire logic [15:0] faults_in,
	input  wire logic        fault_clear,
	input  wire logic        power_on_inhibit_req,
	output logic      [7:0]  state_code,
	output logic             fault_present,
	output logic      [15:0] pending_faults
);
	assign fault_present = fault_in;
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			state_code     <= 8'h00;
			pending_faults <= 16'h0000;
		end else if (load) begin
			state_code     <= code_in;
			pending_faults <= faults_in;
		end else begin
			if (fault_clear)
				pending_faults <= 16'h0000;
			if (power_on_inhibit_req)
				state_code <= `DRV_ST_PON_INH;
		end
	end
endmodule : drive_far_model
`default_nettype wire

// ---- verilog/cw_deenerg_timer.sv ----
// down counter that reports when a de-energization wait has run out
`timescale 1ns/10ps
`default_nettype none

module cw_deenerg_timer #(
	parameter int W = 24
) (
	input  wire logic         clock,
	input  wire logic         sys_rst,
	input  wire logic         start,
	input  wire logic [W-1:0] load,
	output logic              done
);

	typedef struct packed {
		logic [W-1:0] cnt;
		logic         done;
	} state_t;

	state_t state_reg;
	state_t state_next;

	always_comb begin
		state_next = state_reg;
		if (start) begin
			state_next.cnt = load;
		end else if (state_reg.cnt != '0) begin
			state_next.cnt = state_reg.cnt - W'(1);
		end
		state_next.done = (state_next.cnt == '0);
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			state_reg <= '{cnt: '0, done: 1'b1};
		end else begin
			state_reg <= state_next;
		end
	end

	assign done = state_reg.done;

endmodule : cw_deenerg_timer

`default_nettype wire

// ---- verilog/cw_sync_edge.sv ----
// two-stage synchroniser with rise and fall detection per bit
`timescale 1ns/10ps
`default_nettype none

module cw_sync_edge #(
	parameter int W = 4
) (
	input  wire logic         clock,
	input  wire logic         sys_rst,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] level,
	output logic      [W-1:0] rise,
	output logic      [W-1:0] fall
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
	} state_t;

	state_t state_reg;
	state_t state_next;

	always_comb begin
		state_next    = state_reg;
		state_next.s1 = din;
		state_next.s2 = state_reg.s1;
		state_next.s3 = state_reg.s2;
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			assign level[i] = state_reg.s2[i];
			assign rise[i]  = state_reg.s2[i] & ~state_reg.s3[i];
			assign fall[i]  = ~state_reg.s2[i] & state_reg.s3[i];
		end
	endgenerate

endmodule : cw_sync_edge

`default_nettype wire

// ---- verilog/drive_cw_bits.sv ----
// control word bits 6 to 9: setpoint enable, acknowledge and inching
//
// The implementer's own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none

`include "drive_cw_map.svh"

////////////////////////////////////////////////////////////////////////////////
// Functional notes
// RULE1 - setpoint enable output only when bit 6 high and its wait elapsed
// RULE2 - acknowledge rising edge counts only in fault state 007
// RULE3 - on acknowledge, copy pending faults to diagnostics first, then clear
// RULE4 - after acknowledge, go to power-on inhibit 008 if no fault present
// RULE5 - fault still present after acknowledge keeps state at fault 007
// RULE6 - acknowledge works from three sources and operator panel together
// RULE7 - inching-1 rise in state 009 issues ON and selects inching frequency 1
// RULE8 - inching-2 rise in state 009 issues ON and selects inching frequency 2
// RULE9 - bit 0 on command ignored while inching is active
// RULE10 - inching start waits for de-energization time to elapse
// RULE11 - inching bit low issues ramp-down stop, ending inching
module drive_cw_bits #(
	parameter int          NF          = 16,
	parameter int          FW          = 16,
	parameter int          TW          = 24,
	parameter logic [23:0] SP_WAIT_DEF = 24'h000100,
	parameter logic [23:0] DEENERG_DEF = 24'h000100
) (
	input  wire logic          clock,
	input  wire logic          sys_rst,
	input  wire logic [7:0]    bus_addr,
	input  wire logic [31:0]   bus_wdata,
	input  wire logic          bus_wr,
	input  wire logic          bus_rd,
	output logic      [31:0]   bus_rdata,
	input  wire logic [2:0]    ack_src_pin,
	input  wire logic          panel_ack_pin,
	input  wire logic [7:0]    state_code,
	input  wire logic          fault_present,
	input  wire logic [NF-1:0] pending_faults,
	input  wire logic          shutdown_done,
	output logic               setpoint_enable,
	output logic               on_command,
	output logic               ramp_down_stop,
	output logic      [1:0]    setpoint_select,
	output logic      [FW-1:0] inching_setpoint,
	output logic               diag_wr,
	output logic      [NF-1:0] diag_data,
	output logic               fault_clear,
	output logic               power_on_inhibit_req,
	output logic               hold_fault
);

	////////////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		logic [15:0]                ctrl;
		logic [TW-1:0]              sp_wait;
		logic [TW-1:0]              deenerg;
		logic [FW-1:0]              freq1;
		logic [FW-1:0]              freq2;
		logic [31:0]                rdata;
		logic                       ack_prev;
		logic                       inch1_prev;
		logic                       inch2_prev;
		drive_cw_pkg::ack_state_t   ack_st;
		drive_cw_pkg::inch_state_t  inch_st;
		logic                       inch2;
		logic [NF-1:0]              diag;
		logic                       diag_wr;
		logic                       clr;
		logic                       pon;
		logic                       hold;
		logic                       rds;
		logic                       sp_en;
		logic                       on;
		drive_cw_pkg::sp_sel_t      sel;
		logic [FW-1:0]              sp;
	} state_t;

	localparam state_t RESET_STATE = '{
		ctrl:       `CW_CTRL_RST,
		sp_wait:    TW'(SP_WAIT_DEF),
		deenerg:    TW'(DEENERG_DEF),
		freq1:      '0,
		freq2:      '0,
		rdata:      '0,
		ack_prev:   1'b0,
		inch1_prev: 1'b0,
		inch2_prev: 1'b0,
		ack_st:     drive_cw_pkg::ACK_IDLE,
		inch_st:    drive_cw_pkg::INCH_IDLE,
		inch2:      1'b0,
		diag:       '0,
		diag_wr:    1'b0,
		clr:        1'b0,
		pon:        1'b0,
		hold:       1'b0,
		rds:        1'b0,
		sp_en:      1'b0,
		on:         1'b0,
		sel:        drive_cw_pkg::SEL_MAIN,
		sp:         '0
	};

	state_t state_reg;
	state_t state_next;

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers and de-energization timers

	logic [3:0] pin_rise;
	logic       sp_wait_done;
	logic       deenerg_done;

	cw_sync_edge #(
		.W (4)
	) u_ack_sync (
		.clock   (clock),
		.sys_rst (sys_rst),
		.din     ({panel_ack_pin, ack_src_pin}),
		.level   (),
		.rise    (pin_rise),
		.fall    ()
	);

	cw_deenerg_timer #(
		.W (TW)
	) u_sp_wait (
		.clock   (clock),
		.sys_rst (sys_rst),
		.start   (shutdown_done),
		.load    (state_reg.sp_wait),
		.done    (sp_wait_done)
	);

	cw_deenerg_timer #(
		.W (TW)
	) u_deenerg (
		.clock   (clock),
		.sys_rst (sys_rst),
		.start   (shutdown_done),
		.load    (state_reg.deenerg),
		.done    (deenerg_done)
	);

	////////////////////////////////////////////////////////////////////////////
	// next state

	logic        ack_bit;
	logic        inch1_bit;
	logic        inch2_bit;
	logic        ack_edge;
	logic        inch1_rise;
	logic        inch2_rise;
	logic        inch_drop;
	logic        inch_busy;
	logic [31:0] status_word;

	always_comb begin
		state_next = state_reg;
		ack_bit    = state_reg.ctrl[`CW_BIT_ACK];
		inch1_bit  = state_reg.ctrl[`CW_BIT_INCH1];
		inch2_bit  = state_reg.ctrl[`CW_BIT_INCH2];
		ack_edge   = (ack_bit & ~state_reg.ack_prev) | (|pin_rise); // see RULE6
		inch1_rise = inch1_bit & ~state_reg.inch1_prev;
		inch2_rise = inch2_bit & ~state_reg.inch2_prev;
		inch_busy  = (state_reg.inch_st != drive_cw_pkg::INCH_IDLE);
		inch_drop  = inch_busy & (state_reg.inch2 ? ~inch2_bit : ~inch1_bit);

		status_word                    = '0;
		status_word[`ST_BIT_SP_EN]     = state_reg.sp_en;
		status_word[`ST_BIT_ON]        = state_reg.on;
		status_word[`ST_BIT_INCH_RUN]  = (state_reg.inch_st == drive_cw_pkg::INCH_RUN);
		status_word[`ST_BIT_INCH_WAIT] = (state_reg.inch_st == drive_cw_pkg::INCH_WAIT);
		status_word[`ST_BIT_INCH2]     = state_reg.inch2;
		status_word[`ST_BIT_DEEN_DONE] = deenerg_done;
		status_word[`ST_BIT_SPW_DONE]  = sp_wait_done;
		status_word[`ST_BIT_ACK_BUSY]  = (state_reg.ack_st != drive_cw_pkg::ACK_IDLE);
		status_word[`ST_BIT_HOLD]      = state_reg.hold;
		status_word[`ST_BIT_FAULT]     = fault_present;
		status_word[`ST_CODE_LSB +: 8] = state_code;

		state_next.ack_prev   = ack_bit;
		state_next.inch1_prev = inch1_bit;
		state_next.inch2_prev = inch2_bit;

		// register writes
		if (bus_wr) begin
			unique case (bus_addr)
				`CW_OFS_CTRL: begin
					state_next.ctrl = bus_wdata[15:0] & `CW_CTRL_MASK;
				end
				`CW_OFS_SP_WAIT: begin
					state_next.sp_wait = bus_wdata[TW-1:0];
				end
				`CW_OFS_DEENERG: begin
					state_next.deenerg = bus_wdata[TW-1:0];
				end
				`CW_OFS_INCH1: begin
					state_next.freq1 = bus_wdata[FW-1:0];
				end
				`CW_OFS_INCH2: begin
					state_next.freq2 = bus_wdata[FW-1:0];
				end
				default: begin
				end
			endcase
		end

		// register reads, data valid only in the following cycle
		state_next.rdata = '0;
		if (bus_rd) begin
			unique case (bus_addr)
				`CW_OFS_CTRL: begin
					state_next.rdata = {16'h0000, state_reg.ctrl};
				end
				`CW_OFS_SP_WAIT: begin
					state_next.rdata = 32'(state_reg.sp_wait);
				end
				`CW_OFS_DEENERG: begin
					state_next.rdata = 32'(state_reg.deenerg);
				end
				`CW_OFS_INCH1: begin
					state_next.rdata = 32'(state_reg.freq1);
				end
				`CW_OFS_INCH2: begin
					state_next.rdata = 32'(state_reg.freq2);
				end
				`CW_OFS_STATUS: begin
					state_next.rdata = status_word;
				end
				default: begin
					state_next.rdata = '0;
				end
			endcase
		end

		// acknowledge sequence
		state_next.diag_wr = 1'b0;
		state_next.clr     = 1'b0;
		state_next.pon     = 1'b0;
		unique case (state_reg.ack_st)
			drive_cw_pkg::ACK_IDLE: begin
				if (ack_edge && state_code == `DRV_ST_FAULT) begin // see RULE2
					state_next.ack_st = drive_cw_pkg::ACK_COPY;
				end
			end
			drive_cw_pkg::ACK_COPY: begin
				state_next.diag    = pending_faults; // see RULE3
				state_next.diag_wr = 1'b1;
				state_next.ack_st  = drive_cw_pkg::ACK_CLEAR;
			end
			drive_cw_pkg::ACK_CLEAR: begin
				state_next.clr    = 1'b1; // see RULE3
				state_next.ack_st = drive_cw_pkg::ACK_CHECK;
			end
			drive_cw_pkg::ACK_CHECK: begin
				state_next.pon    = ~fault_present; // see RULE4
				state_next.hold   = fault_present; // see RULE5
				state_next.ack_st = drive_cw_pkg::ACK_IDLE;
			end
		endcase
		if (state_code != `DRV_ST_FAULT) begin
			state_next.hold = 1'b0;
		end

		// inching sequence
		state_next.rds = 1'b0;
		unique case (state_reg.inch_st)
			drive_cw_pkg::INCH_IDLE: begin
				if (state_code == `DRV_ST_READY_PU && (inch1_rise || inch2_rise)) begin
					state_next.inch_st = drive_cw_pkg::INCH_WAIT;
					state_next.inch2   = ~inch1_rise; // see RULE8
				end
			end
			drive_cw_pkg::INCH_WAIT: begin
				if (inch_drop) begin
					state_next.inch_st = drive_cw_pkg::INCH_IDLE;
					state_next.rds     = 1'b1; // see RULE11
				end else if (deenerg_done) begin
					state_next.inch_st = drive_cw_pkg::INCH_RUN; // see RULE10
				end
			end
			drive_cw_pkg::INCH_RUN: begin
				if (inch_drop) begin
					state_next.inch_st = drive_cw_pkg::INCH_IDLE;
					state_next.rds     = 1'b1; // see RULE11
				end
			end
			default: begin
				state_next.inch_st = drive_cw_pkg::INCH_IDLE;
			end
		endcase

		// command and setpoint outputs
		unique case (state_next.inch_st)
			drive_cw_pkg::INCH_RUN: begin
				state_next.on = 1'b1; // see RULE7
				if (state_next.inch2) begin
					state_next.sel = drive_cw_pkg::SEL_INCH2; // see RULE8
					state_next.sp  = state_reg.freq2;
				end else begin
					state_next.sel = drive_cw_pkg::SEL_INCH1; // see RULE7
					state_next.sp  = state_reg.freq1;
				end
			end
			drive_cw_pkg::INCH_WAIT: begin
				state_next.on  = 1'b0; // see RULE9
				state_next.sel = drive_cw_pkg::SEL_MAIN;
				state_next.sp  = '0;
			end
			default: begin
				state_next.on  = state_reg.ctrl[`CW_BIT_ON] & ~state_next.rds;
				state_next.sel = drive_cw_pkg::SEL_MAIN;
				state_next.sp  = '0;
			end
		endcase
		state_next.sp_en = state_reg.ctrl[`CW_BIT_SP_EN] & sp_wait_done; // see RULE1
	end

	////////////////////////////////////////////////////////////////////////////
	// registers

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			state_reg <= RESET_STATE;
		end else begin
			state_reg <= state_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs

	assign bus_rdata            = state_reg.rdata;
	assign setpoint_enable      = state_reg.sp_en;
	assign on_command           = state_reg.on;
	assign ramp_down_stop       = state_reg.rds;
	assign setpoint_select      = state_reg.sel;
	assign inching_setpoint     = state_reg.sp;
	assign diag_wr              = state_reg.diag_wr;
	assign diag_data            = state_reg.diag;
	assign fault_clear          = state_reg.clr;
	assign power_on_inhibit_req = state_reg.pon;
	assign hold_fault           = state_reg.hold;

endmodule : drive_cw_bits

`default_nettype wire
